/* pkg/sleep_wake_defines.svh */
// register map, field positions and timing constants of the sleep/wake guard
`ifndef SLEEP_WAKE_DEFINES_SVH
`define SLEEP_WAKE_DEFINES_SVH

// register addresses
`define ADDR_DISCHARGE_CFG 8'h05
`define ADDR_CHARGE_CFG 8'h06
`define ADDR_FEATURE_CFG 8'h07
`define ADDR_WRITE_UNLOCK 8'h08
`define ADDR_POWER_CTRL 8'h09

// write-unlock register fields
`define BIT_FEATURE_UNLOCK 7
`define BIT_CHARGE_UNLOCK 6
`define BIT_DISCHARGE_UNLOCK 5
`define BIT_USER_FLAG_HI 4
`define BIT_USER_FLAG_LO 3

// feature configuration fields
`define BIT_WAKE_POLARITY 0
`define BIT_WAKE_PIN_DISABLE 1
`define BIT_FORCE_POR 2

// power control fields
`define BIT_SLEEP 0
`define BIT_WAKE_STATUS 1

// reset values
`define CFG_RESET 8'h00
`define BYTE_ZERO 8'h00

// timing
`define CLK_PERIOD_NS 20
`define WAKE_FILTER_TIME_NS 50000
`define WAKE_FILTER_CYCLES ((`WAKE_FILTER_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* pkg/sleep_wake_pkg.sv */
// types shared by the sleep/wake guard design
package sleep_wake_pkg;

    // power sequencing states, one-hot
    typedef enum logic [3:0] {
        ST_POR    = 4'b0001,
        ST_AWAKE  = 4'b0010,
        ST_SLEEP  = 4'b0100,
        ST_PSEUDO = 4'b1000
    } power_state_e;

endpackage

/* design/protected_cfg_reg.sv */
// one configuration register whose writes are gated by an unlock bit
`timescale 1ns/1ps
`include "sleep_wake_defines.svh"

module protected_cfg_reg #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // control
    input wire logic i_clear,
    input wire logic i_wr,
    input wire logic i_unlock,
    input wire logic [WIDTH-1:0] i_wdata,
    // state
    output logic [WIDTH-1:0] o_q,
    output logic o_wr_done
);

    logic [WIDTH-1:0] next_q;
    logic next_wr_done;

    // a locked write is dropped with no error; clear beats any write
    always_comb begin
        next_q = o_q;
        next_wr_done = 1'b0;
        if (i_clear) begin
            next_q = WIDTH'(`CFG_RESET);
        end else if (i_wr && i_unlock) begin
            next_q = i_wdata;
            next_wr_done = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_q <= WIDTH'(`CFG_RESET);
            o_wr_done <= 1'b0;
        end else begin
            o_q <= next_q;
            o_wr_done <= next_wr_done;
        end
    end

endmodule

/* design/wake_filter.sv */
// glitch filter: output goes active only after the input stays active long enough
`timescale 1ns/1ps

module wake_filter #(
    parameter int CYCLES = 2500
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // raw and filtered wake level
    input wire logic i_active,
    output logic o_active
);

    localparam int CW = $clog2(CYCLES + 1);

    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic next_active;

    // any inactive cycle restarts the count, so short pulses never pass
    always_comb begin
        next_count = count;
        next_active = o_active;
        if (!i_active) begin
            next_count = '0;
            next_active = 1'b0;
        end else if (count >= CW'(CYCLES - 1)) begin
            next_active = 1'b1;
        end else begin
            next_count = count + CW'(1);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count <= '0;
            o_active <= 1'b0;
        end else begin
            count <= next_count;
            o_active <= next_active;
        end
    end

endmodule

/* design/sleep_wake_guard.sv */
// write protection of the configuration registers and sleep/wake sequencing
`timescale 1ns/1ps
`include "sleep_wake_defines.svh"

module sleep_wake_guard #(
    parameter int WAKE_FILTER_CYC = `WAKE_FILTER_CYCLES
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // supply detectors
    input wire logic i_backup_supply_ok,
    input wire logic i_main_supply_ok,
    // wake pin
    input wire logic i_wake_pin,
    // register port
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // power outputs
    output logic o_regulator_output,
    output logic o_awake,
    output logic o_pseudo_sleep,
    // configuration outputs
    output logic [7:0] o_discharge_cfg,
    output logic [7:0] o_charge_cfg,
    output logic [7:0] o_feature_cfg
);

    sleep_wake_pkg::power_state_e state;
    sleep_wake_pkg::power_state_e next_state;

    logic feature_cfg_write_unlock;
    logic charge_cfg_write_unlock;
    logic discharge_cfg_write_unlock;
    logic user_flag_hi;
    logic user_flag_lo;
    logic next_feature_unlock;
    logic next_charge_unlock;
    logic next_discharge_unlock;
    logic next_user_flag_hi;
    logic next_user_flag_lo;

    logic sleep_bit;
    logic sleep_bit_q;
    logic wake_status;
    logic sleep_armed;
    logic next_sleep_bit;
    logic next_sleep_bit_q;
    logic next_wake_status;
    logic next_sleep_armed;

    logic [7:0] next_rdata;
    logic next_rvalid;
    logic next_regulator;
    logic next_awake;
    logic next_pseudo;

    logic supplies_ok;
    logic force_por;
    logic clear_cfg;
    logic wake_polarity;
    logic wake_pin_disable;
    logic wake_active_raw;
    logic wake_active;
    logic sleep_rise;
    logic sleep_fall;
    logic wr_discharge;
    logic wr_charge;
    logic wr_feature;
    logic feature_done;
    logic disable_released;

    // supply and forced-reset conditions
    assign supplies_ok = i_backup_supply_ok && i_main_supply_ok;
    assign wr_discharge = i_reg_wr && (i_reg_addr == `ADDR_DISCHARGE_CFG);
    assign wr_charge = i_reg_wr && (i_reg_addr == `ADDR_CHARGE_CFG);
    assign wr_feature = i_reg_wr && (i_reg_addr == `ADDR_FEATURE_CFG);
    // forced reset acts only through an accepted (unlocked) feature write
    assign force_por = wr_feature && feature_cfg_write_unlock
        && i_reg_wdata[`BIT_FORCE_POR];
    assign clear_cfg = force_por || !supplies_ok;

    // wake pin qualification
    assign wake_polarity = o_feature_cfg[`BIT_WAKE_POLARITY];
    assign wake_pin_disable = o_feature_cfg[`BIT_WAKE_PIN_DISABLE];
    // polarity picks the active level; disable masks the pin entirely
    assign wake_active_raw = !wake_pin_disable
        && (wake_polarity ? i_wake_pin : !i_wake_pin);

    // sleep bit edges, seen one cycle after the host write
    assign sleep_rise = sleep_bit && !sleep_bit_q;
    assign sleep_fall = !sleep_bit && sleep_bit_q;
    // an accepted feature write that leaves the disable bit clear while the regulator is off
    assign disable_released = feature_done && !wake_pin_disable && o_regulator_output == 1'b0;

    // filter against short glitches on the wake pin
    wake_filter #(
        .CYCLES(WAKE_FILTER_CYC)
    ) u_wake_filter (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_active(wake_active_raw),
        .o_active(wake_active)
    );

    // the three write-protected configuration registers
    protected_cfg_reg #(
        .WIDTH(8)
    ) u_discharge_cfg (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_clear(clear_cfg),
        .i_wr(wr_discharge),
        .i_unlock(discharge_cfg_write_unlock),
        .i_wdata(i_reg_wdata),
        .o_q(o_discharge_cfg),
        .o_wr_done()
    );

    protected_cfg_reg #(
        .WIDTH(8)
    ) u_charge_cfg (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_clear(clear_cfg),
        .i_wr(wr_charge),
        .i_unlock(charge_cfg_write_unlock),
        .i_wdata(i_reg_wdata),
        .o_q(o_charge_cfg),
        .o_wr_done()
    );

    // force-reset bit is never stored: the clear wins over the write
    protected_cfg_reg #(
        .WIDTH(8)
    ) u_feature_cfg (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_clear(clear_cfg),
        .i_wr(wr_feature),
        .i_unlock(feature_cfg_write_unlock),
        .i_wdata(i_reg_wdata),
        .o_q(o_feature_cfg),
        .o_wr_done(feature_done)
    );

    // write-unlock register and user flags
    always_comb begin
        next_feature_unlock = feature_cfg_write_unlock;
        next_charge_unlock = charge_cfg_write_unlock;
        next_discharge_unlock = discharge_cfg_write_unlock;
        next_user_flag_hi = user_flag_hi;
        next_user_flag_lo = user_flag_lo;
        if (i_reg_wr && (i_reg_addr == `ADDR_WRITE_UNLOCK)) begin
            // bits 2..0 are not stored
            next_feature_unlock = i_reg_wdata[`BIT_FEATURE_UNLOCK];
            next_charge_unlock = i_reg_wdata[`BIT_CHARGE_UNLOCK];
            next_discharge_unlock = i_reg_wdata[`BIT_DISCHARGE_UNLOCK];
            next_user_flag_hi = i_reg_wdata[`BIT_USER_FLAG_HI];
            next_user_flag_lo = i_reg_wdata[`BIT_USER_FLAG_LO];
        end
        // unlock bits fall back to locked whenever the device re-powers
        if (clear_cfg) begin
            next_feature_unlock = 1'b0;
            next_charge_unlock = 1'b0;
            next_discharge_unlock = 1'b0;
        end
        // user flags live on the backup supply: only its loss or a forced reset clears them
        if (force_por || !i_backup_supply_ok) begin
            next_user_flag_hi = 1'b0;
            next_user_flag_lo = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            feature_cfg_write_unlock <= 1'b0;
            charge_cfg_write_unlock <= 1'b0;
            discharge_cfg_write_unlock <= 1'b0;
            user_flag_hi <= 1'b0;
            user_flag_lo <= 1'b0;
        end else begin
            feature_cfg_write_unlock <= next_feature_unlock;
            charge_cfg_write_unlock <= next_charge_unlock;
            discharge_cfg_write_unlock <= next_discharge_unlock;
            user_flag_hi <= next_user_flag_hi;
            user_flag_lo <= next_user_flag_lo;
        end
    end

    // power sequencing state machine
    always_comb begin
        next_state = state;
        case (state)
            sleep_wake_pkg::ST_POR: begin
                if (supplies_ok) begin
                    next_state = sleep_wake_pkg::ST_AWAKE;
                end
            end
            sleep_wake_pkg::ST_AWAKE: begin
                // armed, or pin inactive, lets a sleep rise through
                if (sleep_rise && (sleep_armed || !wake_active)) begin
                    next_state = sleep_wake_pkg::ST_SLEEP;
                end
            end
            sleep_wake_pkg::ST_SLEEP: begin
                if (wake_active || disable_released) begin
                    next_state = sleep_wake_pkg::ST_PSEUDO;
                end
            end
            sleep_wake_pkg::ST_PSEUDO: begin
                // full wake only once the status bit has been latched
                if (wake_status) begin
                    next_state = sleep_wake_pkg::ST_AWAKE;
                end
            end
            default: begin
                next_state = sleep_wake_pkg::ST_POR;
            end
        endcase
        if (!supplies_ok || force_por) begin
            next_state = sleep_wake_pkg::ST_POR;
        end
    end

    // sleep bit, wake status and sleep arming
    always_comb begin
        next_sleep_bit = sleep_bit;
        next_sleep_bit_q = sleep_bit;
        next_wake_status = wake_status;
        next_sleep_armed = sleep_armed;
        if (i_reg_wr && (i_reg_addr == `ADDR_POWER_CTRL)) begin
            next_sleep_bit = i_reg_wdata[`BIT_SLEEP];
        end
        // a fall seen while awake, or an inactive pin, re-arms; the hardware clear on wake does not
        if ((sleep_fall && state == sleep_wake_pkg::ST_AWAKE) || !wake_active) begin
            next_sleep_armed = 1'b1;
        end else if (state != sleep_wake_pkg::ST_AWAKE) begin
            next_sleep_armed = 1'b0;
        end
        if (state == sleep_wake_pkg::ST_PSEUDO) begin
            next_wake_status = 1'b1;
        end else if (state == sleep_wake_pkg::ST_SLEEP) begin
            next_wake_status = 1'b0;
        end
        // status rise clears the sleep bit; hardware clear wins over a host set
        if (state == sleep_wake_pkg::ST_PSEUDO && !wake_status) begin
            next_sleep_bit = 1'b0;
        end
        if (!supplies_ok || force_por) begin
            next_sleep_bit = 1'b0;
            next_sleep_bit_q = 1'b0;
            next_wake_status = 1'b0;
            next_sleep_armed = 1'b0;
        end
    end

    // power outputs and read data
    always_comb begin
        next_regulator = (next_state != sleep_wake_pkg::ST_POR)
            && (next_state != sleep_wake_pkg::ST_SLEEP);
        next_awake = (next_state == sleep_wake_pkg::ST_AWAKE);
        next_pseudo = (next_state == sleep_wake_pkg::ST_PSEUDO);
        next_rvalid = i_reg_rd;
        next_rdata = `BYTE_ZERO;
        if (!i_reg_rd) begin
            next_rdata = `BYTE_ZERO;
        end else if (i_reg_addr == `ADDR_DISCHARGE_CFG) begin
            next_rdata = o_discharge_cfg;
        end else if (i_reg_addr == `ADDR_CHARGE_CFG) begin
            next_rdata = o_charge_cfg;
        end else if (i_reg_addr == `ADDR_FEATURE_CFG) begin
            next_rdata = o_feature_cfg;
        end else if (i_reg_addr == `ADDR_WRITE_UNLOCK) begin
            next_rdata[`BIT_FEATURE_UNLOCK] = feature_cfg_write_unlock;
            next_rdata[`BIT_CHARGE_UNLOCK] = charge_cfg_write_unlock;
            next_rdata[`BIT_DISCHARGE_UNLOCK] = discharge_cfg_write_unlock;
            next_rdata[`BIT_USER_FLAG_HI] = user_flag_hi;
            next_rdata[`BIT_USER_FLAG_LO] = user_flag_lo;
        end else if (i_reg_addr == `ADDR_POWER_CTRL) begin
            next_rdata[`BIT_SLEEP] = sleep_bit;
            next_rdata[`BIT_WAKE_STATUS] = wake_status;
        end
    end

    // sequencing, status and output registers; reset leaves the regulator off until supplies are seen good
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= sleep_wake_pkg::ST_POR;
            sleep_bit <= 1'b0;
            sleep_bit_q <= 1'b0;
            wake_status <= 1'b0;
            sleep_armed <= 1'b0;
            o_regulator_output <= 1'b0;
            o_awake <= 1'b0;
            o_pseudo_sleep <= 1'b0;
            o_reg_rdata <= `BYTE_ZERO;
            o_reg_rvalid <= 1'b0;
        end else begin
            state <= next_state;
            sleep_bit <= next_sleep_bit;
            sleep_bit_q <= next_sleep_bit_q;
            wake_status <= next_wake_status;
            sleep_armed <= next_sleep_armed;
            o_regulator_output <= next_regulator;
            o_awake <= next_awake;
            o_pseudo_sleep <= next_pseudo;
            o_reg_rdata <= next_rdata;
            o_reg_rvalid <= next_rvalid;
        end
    end

endmodule

/* dv/sleep_wake_guard_asserts.sv */
// port-level checker for the sleep/wake guard
`timescale 1ns/1ps

module sleep_wake_guard_asserts #(
    parameter int WAKE_FILTER_CYC = 4
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // inputs watched
    input wire logic i_backup_supply_ok,
    input wire logic i_main_supply_ok,
    input wire logic i_wake_pin,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_addr,
    // outputs watched
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    input wire logic o_regulator_output,
    input wire logic o_awake,
    input wire logic o_pseudo_sleep,
    input wire logic [7:0] o_discharge_cfg,
    input wire logic [7:0] o_feature_cfg
);
    logic [15:0] run;
    logic [15:0] next_run;

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    // run length of the raw pin at its active level, saturating so it never wraps
    always_comb begin
        next_run = (i_wake_pin == o_feature_cfg[0]) ? run + 16'h0001 : 16'h0000;
        if (&run) begin
            next_run = run;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            run <= 16'h0000;
        end else begin
            run <= next_run;
        end
    end

    a_pseudo_powered: assert property (o_pseudo_sleep |-> o_regulator_output)
        else $error("regulator off in pseudo-sleep");
    a_pseudo_to_awake: assert property ($rose(o_pseudo_sleep) |-> ##[1:3] o_awake)
        else $error("pseudo-sleep did not finish waking");
    a_wake_needs_supply: assert property ($rose(o_awake) |->
        $past(i_main_supply_ok) && $past(i_backup_supply_ok))
        else $error("awake without both supplies");
    a_supply_drop_off: assert property (!(i_main_supply_ok && i_backup_supply_ok) |=>
        !o_awake && !o_regulator_output)
        else $error("still powered after supply loss");
    a_cfg_needs_write: assert property ($changed(o_discharge_cfg) |->
        $past(i_reg_wr) || $past(i_reg_wr, 2) || !$past(i_main_supply_ok)
        || !$past(i_backup_supply_ok))
        else $error("discharge config changed without cause");
    a_force_bit_clear: assert property (o_feature_cfg[2] == 1'b0)
        else $error("force reset bit held");
    a_reserved_zero: assert property (o_reg_rvalid && $past(i_reg_addr) == 8'h08 |->
        o_reg_rdata[2:0] == 3'b000)
        else $error("reserved unlock bits not zero");
    a_wake_filtered: assert property ($rose(o_pseudo_sleep)
        && !($past(i_reg_wr, 2) && $past(i_reg_addr, 2) == 8'h07) |-> run >= WAKE_FILTER_CYC)
        else $error("wake taken before filter time");
    a_pin_disabled: assert property (o_feature_cfg[1] && !o_regulator_output
        && !(i_reg_wr && i_reg_addr == 8'h07) |=> !o_regulator_output)
        else $error("woke with wake pin disabled");
endmodule

bind sleep_wake_guard sleep_wake_guard_asserts #(
    .WAKE_FILTER_CYC(WAKE_FILTER_CYC)
) u_chk (.*);

/* dv/wake_source_model.sv */
// wake source on the far side of the wake pin
`timescale 1ns/1ps

module wake_source_model (
    // request from the bench
    input wire logic i_req,
    input wire logic i_pol,
    // pin level seen by the device
    output logic o_pin
);
    // idle sits at the inverse of the active level, so no stray wake while idle
    assign o_pin = i_req ? i_pol : ~i_pol;
endmodule

/* dv/tb_top.sv */
// self-checking bench for the sleep/wake guard
`timescale 1ns/1ps

module tb_top;
    localparam int FILT = 4;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_backup_supply_ok = 1'b1;
    logic i_main_supply_ok = 1'b1;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic [7:0] i_reg_addr = 8'h00;
    logic [7:0] i_reg_wdata = 8'h00;
    logic wake_req = 1'b0;
    logic wake_pol = 1'b0;
    logic i_wake_pin;
    logic [7:0] o_reg_rdata;
    logic o_reg_rvalid;
    logic o_regulator_output;
    logic o_awake;
    logic o_pseudo_sleep;
    logic [7:0] o_discharge_cfg;
    logic [7:0] o_charge_cfg;
    logic [7:0] o_feature_cfg;
    int errors = 0;
    int checks_done = 0;

    always #10 i_clk = ~i_clk;

    wake_source_model u_wake (.i_req(wake_req), .i_pol(wake_pol), .o_pin(i_wake_pin));

    // short filter keeps the wake tests brief
    sleep_wake_guard #(.WAKE_FILTER_CYC(FILT)) uut (.*);

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
        @(posedge i_clk);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_clk);
        i_reg_rd <= 1'b0;
        #1;
        chk("rvalid", 8'h01, {7'h00, o_reg_rvalid});
        chk(nm, exp, o_reg_rdata);
    endtask

    // bounded wait on the awake level; running out counts as a mismatch
    task automatic wait_aw(input logic exp, input int lim, input string nm);
        int n;
        n = 0;
        while (o_awake !== exp && n < lim) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        chk(nm, {7'h00, exp}, {7'h00, o_awake});
    endtask

    task automatic pin(input logic v);
        @(posedge i_clk);
        wake_req <= v;
    endtask

    task automatic t_lock();
        logic [23:0] cfg;
        wait_aw(1'b1, 4, "power-up awake");
        rd(8'h08, 8'h00, "unlock at power-up");
        // one unlock bit at a time; the other two writes must be dropped
        for (int i = 0; i < 3; i++) begin
            wr(8'h08, 8'h20 << i);
            for (int j = 0; j < 3; j++) begin
                wr(8'h05 + 8'(j), 8'h08);
            end
            #1;
            cfg = {o_feature_cfg, o_charge_cfg, o_discharge_cfg};
            for (int j = 0; j < 3; j++) begin
                chk("cfg", (j <= i) ? 8'h08 : 8'h00, cfg[j*8 +: 8]);
            end
        end
        wr(8'h08, 8'hFF);
        rd(8'h08, 8'hF8, "unlock readback");
        rd(8'h3C, 8'h00, "unmapped");
        $display("t_lock done");
    endtask

    task automatic t_sleep_wake(input logic pol);
        wr(8'h08, 8'hE0);
        wr(8'h07, {7'h00, pol});
        wake_pol <= pol;
        wr(8'h09, 8'h01);
        wait_aw(1'b0, 4, "sleep on rise");
        chk("regulator", 8'h00, {7'h00, o_regulator_output});
        pin(1'b1);
        repeat (FILT - 1) @(posedge i_clk);
        wake_req <= 1'b0;
        repeat (8) @(posedge i_clk);
        #1;
        chk("short pulse", 8'h00, {7'h00, o_regulator_output});
        pin(1'b1);
        wait_aw(1'b1, 20, "wake");
        pin(1'b0);
        rd(8'h09, 8'h02, "power ctrl");
        $display("t_sleep_wake pol %0d done", pol);
    endtask

    task automatic t_armed();
        wr(8'h07, 8'h00);
        wake_pol <= 1'b0;
        wr(8'h09, 8'h01);
        wait_aw(1'b0, 4, "asleep");
        pin(1'b1);
        wait_aw(1'b1, 20, "woken, pin held");
        wr(8'h09, 8'h01);
        repeat (4) @(posedge i_clk);
        #1;
        chk("unarmed rise", 8'h01, {7'h00, o_awake});
        wr(8'h09, 8'h00);
        wr(8'h09, 8'h01);
        wait_aw(1'b0, 4, "armed rise");
        wait_aw(1'b1, 20, "held pin rewakes");
        pin(1'b0);
        $display("t_armed done");
    endtask

    task automatic t_pin_dis();
        wr(8'h07, 8'h02);
        wr(8'h09, 8'h01);
        wait_aw(1'b0, 4, "asleep, pin off");
        pin(1'b1);
        repeat (20) @(posedge i_clk);
        #1;
        chk("pin ignored", 8'h00, {7'h00, o_regulator_output});
        // release the pin first so only the enabling write can wake
        pin(1'b0);
        wr(8'h07, 8'h00);
        @(posedge i_clk);
        #1;
        chk("pseudo-sleep", 8'h01, {7'h00, o_pseudo_sleep});
        wait_aw(1'b1, 20, "wake by enable");
        $display("t_pin_dis done");
    endtask

    task automatic t_supply();
        wr(8'h08, 8'hF8);
        wr(8'h05, 8'h3C);
        @(posedge i_clk);
        i_main_supply_ok <= 1'b0;
        wait_aw(1'b0, 3, "supply lost");
        @(posedge i_clk);
        i_main_supply_ok <= 1'b1;
        wait_aw(1'b1, 4, "supply back");
        chk("discharge cfg", 8'h00, o_discharge_cfg);
        rd(8'h08, 8'h18, "flags kept");
        $display("t_supply done");
    endtask

    task automatic t_por();
        wr(8'h08, 8'h98);
        wr(8'h07, 8'h04);
        #1;
        chk("forced reset", 8'h00, {7'h00, o_awake});
        wait_aw(1'b1, 6, "awake after reset");
        rd(8'h08, 8'h00, "unlock cleared");
        chk("feature cfg", 8'h00, o_feature_cfg);
        $display("t_por done");
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (4) @(posedge i_clk);
        i_rst_n <= 1'b1;
        t_lock();
        t_sleep_wake(1'b0);
        t_sleep_wake(1'b1);
        t_armed();
        t_pin_dis();
        t_supply();
        t_por();
        wrap_up();
    end

    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        errors++;
        $display("[ERR] watchdog expected finish seen timeout");
        wrap_up();
    end
endmodule
